// >>> verilog/event_irq_pkg.sv
package event_irq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] line_flags_addr = 8'h00;
  localparam logic [7:0] maint_flags_addr = 8'h04;
  localparam logic [7:0] line_mask_addr = 8'h08;
  localparam logic [7:0] maint_mask_addr = 8'h0c;
  localparam logic [7:0] summary_addr = 8'h10;
  localparam logic [7:0] control_addr = 8'h14;

  // Field positions
  localparam int summary_line_bit = 0;
  localparam int summary_maint_bit = 1;
  localparam int control_auto_bit = 0;

  // Values after reset
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [7:0] mask_reset = 8'hff;
  localparam logic auto_reset = 1'b1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int clk_mhz = 40;
  localparam int hold_time_us = 50;
  localparam int hold_cycles = hold_time_us * clk_mhz;
  localparam int hold_cnt_w = 12;

  // ****************************************************************
  // Bus carriers
  // ****************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// >>> verilog/hold_timer.sv
`timescale 1ns/10ps
module hold_timer
  import event_irq_pkg::*;
#(
  parameter int cycles = hold_cycles
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Control
  input wire logic start_i,
  // Status
  output logic active_o
);

  logic [hold_cnt_w-1:0] count_reg;
  logic [hold_cnt_w-1:0] count_next;
  logic active_next;

  // Reload on every start, otherwise count down to zero
  assign count_next = start_i ? hold_cnt_w'(cycles - 1) :
                      (count_reg != '0) ? count_reg - hold_cnt_w'(1) : count_reg;
  assign active_next = start_i | (count_reg != '0);

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= '0;
      active_o <= 1'b0;
    end else begin
      count_reg <= count_next;
      active_o <= active_next;
    end
  end

endmodule // hold_timer

// >>> verilog/host_interrupt_aggregator.sv
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - Interrupt low on any set unmasked flag
// - Flags latch regardless of mask
// - Unmasking pending flag pulls interrupt low
// - Flag read clears register, interrupt high 50us
// - After hold, interrupt follows unmasked flags
// - Summary register shows pending per register
// - Serial data out driven only during reads
module host_interrupt_aggregator
  import event_irq_pkg::*;
#(
  parameter int flag_w = 8,
  parameter int hold_len = hold_cycles
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register bus
  input wire apb_req_t apb_req_i,
  output apb_rsp_t apb_rsp_o,
  // Event conditions
  input wire logic [flag_w-1:0] line_event_i,
  input wire logic [flag_w-1:0] maint_event_i,
  // Host side pins
  output logic int_n_o,
  output logic serial_host_data_out_o,
  output logic serial_host_data_out_oe_o,
  // Configuration
  output logic auto_maintenance_control_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [flag_w-1:0] line_flags_reg, line_flags_next;
  logic [flag_w-1:0] maint_flags_reg, maint_flags_next;
  logic [flag_w-1:0] line_mask_reg, maint_mask_reg;
  logic [flag_w-1:0] line_prev_reg, maint_prev_reg;
  logic [flag_w-1:0] line_set, maint_set;
  logic line_pend, maint_pend, any_pend;
  logic setup, access, rd_done, wr_done;
  logic rd_line, rd_maint, hold_active;
  logic mapped;
  logic [31:0] rd_word;
  logic int_n_next;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign setup = apb_req_i.psel & ~apb_req_i.penable;
  assign access = apb_req_i.psel & apb_req_i.penable & apb_rsp_o.pready;
  assign rd_done = access & ~apb_req_i.pwrite;
  assign wr_done = access & apb_req_i.pwrite;
  assign rd_line = rd_done & (apb_req_i.paddr == line_flags_addr);
  assign rd_maint = rd_done & (apb_req_i.paddr == maint_flags_addr);
  assign mapped = (apb_req_i.paddr == line_flags_addr) | (apb_req_i.paddr == maint_flags_addr) |
                  (apb_req_i.paddr == line_mask_addr) | (apb_req_i.paddr == maint_mask_addr) |
                  (apb_req_i.paddr == summary_addr) | (apb_req_i.paddr == control_addr);

  // Read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    case (apb_req_i.paddr)
      line_flags_addr: rd_word[flag_w-1:0] = line_flags_reg;
      maint_flags_addr: rd_word[flag_w-1:0] = maint_flags_reg;
      line_mask_addr: rd_word[flag_w-1:0] = line_mask_reg;
      maint_mask_addr: rd_word[flag_w-1:0] = maint_mask_reg;
      summary_addr: begin
        rd_word[summary_line_bit] = line_pend;
        rd_word[summary_maint_bit] = maint_pend;
      end
      control_addr: rd_word[control_auto_bit] = auto_maintenance_control_o;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************
  // Rising condition sets a flag; mask plays no part here
  assign line_set = line_event_i & ~line_prev_reg;
  assign maint_set = maint_event_i & ~maint_prev_reg;
  // Read clears whole register, a new event in that cycle still wins
  assign line_flags_next = (rd_line ? '0 : line_flags_reg) | line_set;
  assign maint_flags_next = (rd_maint ? '0 : maint_flags_reg) | maint_set;

  // Pending unmasked status
  assign line_pend = |(line_flags_reg & ~line_mask_reg);
  assign maint_pend = |(maint_flags_reg & ~maint_mask_reg);
  assign any_pend = line_pend | maint_pend;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      line_flags_reg <= flags_reset;
      maint_flags_reg <= flags_reset;
      line_prev_reg <= flags_reset;
      maint_prev_reg <= flags_reset;
    end else begin
      line_flags_reg <= line_flags_next;
      maint_flags_reg <= maint_flags_next;
      line_prev_reg <= line_event_i;
      maint_prev_reg <= maint_event_i;
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      line_mask_reg <= mask_reset;
      maint_mask_reg <= mask_reset;
      auto_maintenance_control_o <= auto_reset;
    end else if (wr_done) begin
      if (apb_req_i.paddr == line_mask_addr) line_mask_reg <= apb_req_i.pwdata[flag_w-1:0];
      if (apb_req_i.paddr == maint_mask_addr) maint_mask_reg <= apb_req_i.pwdata[flag_w-1:0];
      if (apb_req_i.paddr == control_addr) auto_maintenance_control_o <= apb_req_i.pwdata[control_auto_bit];
    end
  end

  // ****************************************************************
  // Bus response, one wait-free access phase
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      apb_rsp_o <= '0;
    end else begin
      apb_rsp_o.pready <= setup;
      apb_rsp_o.pslverr <= setup & ~mapped;
      if (setup) apb_rsp_o.prdata <= rd_word;
    end
  end

  // ****************************************************************
  // Forced-high hold after a clearing read
  // ****************************************************************
  hold_timer #(
    .cycles(hold_len)
  ) u_hold (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .start_i(rd_line | rd_maint),
    .active_o(hold_active)
  );

  // Interrupt level: high during hold, else follows pending
  assign int_n_next = (rd_line | rd_maint | hold_active) ? 1'b1 : ~any_pend;

  // ****************************************************************
  // Host pins
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      int_n_o <= 1'b1;
      serial_host_data_out_o <= 1'b0;
      serial_host_data_out_oe_o <= 1'b0;
    end else begin
      int_n_o <= int_n_next;
      serial_host_data_out_oe_o <= setup & ~apb_req_i.pwrite;
      serial_host_data_out_o <= setup & ~apb_req_i.pwrite & rd_word[0];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Cycles the hold has stood since its last restart
  logic [hold_cnt_w:0] hold_run_reg;
  logic [hold_cnt_w:0] hold_run_next;

  // Restart on a clearing read, count while held, idle at zero
  assign hold_run_next = (rd_line | rd_maint) ? '0 :
                         hold_active ? hold_run_reg + (hold_cnt_w + 1)'(1) : '0;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      hold_run_reg <= '0;
    end else begin
      hold_run_reg <= hold_run_next;
    end
  end

  sequence clearing_read;
    rd_line | rd_maint;
  endsequence

  a_int_follows_pend: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!hold_active && !rd_line && !rd_maint) |=> (int_n_o == !$past(any_pend)))
    else $error("interrupt does not follow pending flags");

  a_flag_sets_masked: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (line_event_i[0] && !line_prev_reg[0]) |=> line_flags_reg[0])
    else $error("event flag not latched");

  a_unmask_raises: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (line_flags_reg[0] && line_mask_reg[0] && wr_done && apb_req_i.paddr == line_mask_addr &&
     !apb_req_i.pwdata[0] && !rd_line && !rd_maint && !hold_active) |=> ##1 !int_n_o)
    else $error("unmasked pending flag gives no interrupt");

  a_read_clears: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_line |=> ((line_flags_reg & ~$past(line_set)) == '0))
    else $error("read did not clear flags");

  a_hold_high: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clearing_read |=> int_n_o [*8])
    else $error("interrupt not held high after read");

  a_hold_ends: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    hold_active |-> (hold_run_reg < hold_len))
    else $error("hold interval never ends");

  a_summary_bits: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (setup && apb_req_i.paddr == summary_addr) |=> (apb_rsp_o.prdata[1:0] == {$past(maint_pend), $past(line_pend)}))
    else $error("summary register wrong");

  a_sdo_only_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    serial_host_data_out_oe_o |-> $past(setup && !apb_req_i.pwrite))
    else $error("data out driven outside a read");

  a_timer_restart: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clearing_read |=> hold_active)
    else $error("hold timer not restarted");

endmodule // host_interrupt_aggregator

// >>> verification/host_cpu_model.sv
`timescale 1ns/10ps
module host_cpu_model
  import event_irq_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Register bus
  output apb_req_t apb_req_o,
  input wire apb_rsp_t apb_rsp_i
);
  // ********************
  // Host bus master
  // ********************
  initial apb_req_o = '0;

  // Transfers that never saw pready
  int n_timeouts = 0;

  // One transfer; released lines carry inverted values
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    apb_req_o <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys_i);
    apb_req_o.penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (apb_rsp_i.pready !== 1'b1 && n < 64);
    if (n >= 64) n_timeouts++;
    rd = (n < 64) ? apb_rsp_i.prdata : 'x;
    err = apb_rsp_i.pslverr;
    apb_req_o <= '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask
endmodule // host_cpu_model

// >>> verification/host_interrupt_aggregator_tb_top.sv
`timescale 1ns/10ps
module host_interrupt_aggregator_tb_top
  import event_irq_pkg::*;
;
  localparam int hl = 16;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic [7:0] line_ev = 8'h00;
  logic [7:0] maint_ev = 8'h00;
  logic int_n, serial_host_data_out, sdo_oe, auto_ctl, err;
  logic [31:0] rd;
  int err_total = 0;
  int n_compared = 0;
  int cnt;

  // Clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  host_interrupt_aggregator #(.flag_w(8), .hold_len(hl)) host_interrupt_aggregator_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .apb_req_i(apb_req), .apb_rsp_o(apb_rsp),
    .line_event_i(line_ev), .maint_event_i(maint_ev), .int_n_o(int_n),
    .serial_host_data_out_o(serial_host_data_out), .serial_host_data_out_oe_o(sdo_oe),
    .auto_maintenance_control_o(auto_ctl));
  host_cpu_model host_cpu_model_inst (.clk_sys_i(clk_sys_i), .apb_req_o(apb_req), .apb_rsp_i(apb_rsp));

  // ********************
  // Helpers
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host_cpu_model_inst.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_cpu_model_inst.xfer(1'b1, a, d, rd, err);
  endtask

  // Counts edges while the interrupt stays high
  task automatic time_high;
    cnt = 0;
    while (int_n === 1'b1 && cnt < 200) begin
      @(posedge clk_sys_i);
      cnt++;
    end
  endtask

  task automatic give_verdict;
    err_total += host_cpu_model_inst.n_timeouts;
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Data-out pin enabled only in a read access
  always @(posedge clk_sys_i) begin
    if (!reset_i) chk({sdo_oe, serial_host_data_out}, {apb_req.psel & apb_req.penable & ~apb_req.pwrite, sdo_oe & apb_rsp.prdata[0]});
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk(int_n, 1'b1);
    // Reset values and unmapped place
    rd_chk(line_mask_addr, 32'h0000_00ff);
    rd_chk(maint_mask_addr, 32'h0000_00ff);
    rd_chk(summary_addr, 32'h0);
    rd_chk(control_addr, 32'h1);
    rd_chk(8'h18, 32'h0);
    chk(err, 1'b1);
    // Host takes over maintenance actions
    wr(control_addr, 32'h0);
    @(posedge clk_sys_i);
    chk(auto_ctl, 1'b0);
    // Masked events latch quietly, then unmasking reports them
    line_ev <= 8'h05;
    repeat (4) @(posedge clk_sys_i);
    chk(int_n, 1'b1);
    rd_chk(summary_addr, 32'h0);
    wr(maint_mask_addr, 32'h0000_00fe);
    wr(line_mask_addr, 32'h0000_00fa);
    time_high;
    chk(cnt >= 1 && cnt <= 3, 1'b1);
    rd_chk(summary_addr, 32'h1);
    // Clearing read; new event waits for the hold to end
    rd_chk(line_flags_addr, 32'h5);
    line_ev <= 8'h00;
    maint_ev <= 8'h01;
    repeat (2) @(posedge clk_sys_i);
    time_high;
    chk(cnt >= hl - 2 && cnt <= hl + 3, 1'b1);
    rd_chk(summary_addr, 32'h2);
    rd_chk(line_flags_addr, 32'h0);
    rd_chk(maint_flags_addr, 32'h1);
    // Second read inside the hold restarts it
    repeat (10) @(posedge clk_sys_i);
    rd_chk(maint_flags_addr, 32'h0);
    line_ev <= 8'h01;
    repeat (2) @(posedge clk_sys_i);
    time_high;
    chk(cnt >= hl - 2 && cnt <= hl + 3, 1'b1);
    rd_chk(summary_addr, 32'h1);
    give_verdict;
  end
endmodule // host_interrupt_aggregator_tb_top
